/* design/uhd_detach_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module uhd_detach_timer #(
  parameter int CYCLES = uhd_pkg::UHD_DETACH_CYCLES,
  parameter int CNT_W = 10
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset
  input wire logic se0, // Both lines low, synchronised
  output logic detach // One-cycle pulse on detach
);
  import uhd_pkg::*;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
  logic [CNT_W-1:0] count;
  logic fired;

  // Counts from the first low sample; saturates after firing once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      fired <= 1'b0;
      detach <= 1'b0;
    end else if (!se0) begin
      count <= '0;
      fired <= 1'b0;
      detach <= 1'b0;
    end else begin
      detach <= 1'b0;
      if (!fired && count == LAST) begin
        fired <= 1'b1;
        detach <= 1'b1;
      end else if (!fired) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule : uhd_detach_timer
`default_nettype wire

/* design/uhd_ep_dma.sv */
`timescale 1ns/1ps
`default_nettype none
module uhd_ep_dma #(
  parameter int PKT_W = 10,
  parameter int CNT_W = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset
  input wire logic pkt_done, // Packet finished normally
  input wire logic flag_clear, // Software write-one-to-clear
  input wire logic auto_en, // Automatic buffer mode
  input wire logic gate, // DMA request gate
  input wire logic [PKT_W-1:0] max_pkt, // Packet size in bytes
  input wire logic load_total, // Block count written
  input wire logic [CNT_W-1:0] total, // Total bytes for auto mode
  input wire logic dma_ack, // One word moved by DMA
  output logic flag, // Data request flag
  output logic dma_req, // Request to the DMA controller
  output logic [CNT_W-1:0] remaining // Bytes left in auto mode
);
  import uhd_pkg::*;
  localparam logic [PKT_W:0] STEP = (PKT_W+1)'(UHD_BYTES_PER_ACK);
  localparam logic [CNT_W-1:0] STEP_C = CNT_W'(UHD_BYTES_PER_ACK);
  logic [PKT_W:0] moved;
  logic [PKT_W:0] next_moved;
  logic [CNT_W-1:0] next_remaining;
  logic next_flag;
  logic pkt_full;
  logic auto_ack;

  always_comb begin
    auto_ack = auto_en && dma_ack && flag;
    next_moved = moved;
    next_remaining = remaining;
    pkt_full = 1'b0;
    if (load_total) begin
      next_remaining = total;
      next_moved = '0;
    end else if (auto_ack) begin
      // Last ack zeroes any remainder below a word: odd totals end by DMA with a part-filled word
      if (remaining > STEP_C) begin
        next_remaining = remaining - STEP_C;
      end else begin
        next_remaining = '0;
      end
      if (moved + STEP >= {1'b0, max_pkt}) begin
        pkt_full = 1'b1;
        next_moved = '0;
      end else begin
        next_moved = moved + STEP;
      end
    end
    // Set wins over any clear in the same cycle
    if (pkt_done) begin
      next_flag = 1'b1;
    end else if (flag_clear) begin
      next_flag = 1'b0;
    end else if (pkt_full || (auto_ack && next_remaining == '0)) begin
      next_flag = 1'b0;
    end else begin
      next_flag = flag;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
      moved <= '0;
      remaining <= '0;
    end else begin
      flag <= next_flag;
      moved <= next_moved;
      remaining <= next_remaining;
    end
  end

  // Registered from next state so an ack never overruns by a word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dma_req <= 1'b0;
    end else begin
      dma_req <= next_flag && gate &&
                 (!auto_en || next_remaining != '0);
    end
  end
endmodule : uhd_ep_dma
`default_nettype wire

/* design/uhd_host_link.sv */
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module uhd_host_link #(
  parameter int PKT_W = 10,
  parameter int CNT_W = 16,
  parameter int DETACH_CYCLES = uhd_pkg::UHD_DETACH_CYCLES
) (
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic rst, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [1:0] pkt_done, // Endpoint packet ended normally
  input wire logic [PKT_W-1:0] ep1_rx_size, // Ep1 received bytes
  input wire logic [PKT_W-1:0] ep2_rx_size, // Ep2 received bytes
  input wire logic usb_bus_reset, // Bus reset issued by engine
  input wire logic [1:0] dma_ack, // DMA moved one word
  output logic [1:0] dma_req, // DMA request per endpoint
  input wire logic dp_in, // D+ line level
  input wire logic dm_in, // D- line level
  input wire logic tx_dp, // Engine D+ drive value
  input wire logic tx_dm, // Engine D- drive value
  input wire logic tx_oe, // Engine wants to drive
  output logic dp_out, // D+ output value
  output logic dm_out, // D- output value
  output logic line_oe, // Line drive enable
  output logic core_clk_run, // Clock request for idle logic
  output logic host_irq // Host event interrupt
);
  import uhd_pkg::*;

  uhd_pwr_type pwr_state;
  logic [1:0] line_meta;
  logic [1:0] line_sync;
  logic se0;
  logic kstate;
  logic detach_pulse;
  logic connect_event;
  logic wr_en;
  logic rd_en;
  logic [PKT_W-1:0] pkt_size [2];
  logic [1:0] auto_en;
  logic [CNT_W-1:0] blk_total [2];
  logic [1:0] blk_load;
  logic [1:0] dma_gate;
  logic [1:0] ep_flag;
  logic [1:0] ep_clear;
  logic [1:0] ep_req;
  logic [CNT_W-1:0] ep_left [2];
  logic attach_state;
  logic low_power_hold_bit;
  logic detach_flag;
  logic wake_event_flag;
  logic detach_irq_enable;
  logic wake_irq_enable;
  logic resume_cause;
  logic [31:0] next_rdata;
  logic next_err;

  // Line levels come from the pins: two stages first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_meta <= 2'h0;
      line_sync <= 2'h0;
    end else begin
      line_meta <= {dp_in, dm_in};
      line_sync <= line_meta;
    end
  end

  assign se0 = (line_sync == 2'b00);
  assign kstate = (line_sync == 2'b01);
  assign connect_event = !attach_state && !se0;

  // APB: one wait state, then pready for one cycle
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // Endpoint control and block count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pkt_size[0] <= UHD_PKT_RST;
      pkt_size[1] <= UHD_PKT_RST;
      auto_en <= 2'h0;
      blk_total[0] <= UHD_BLK_RST;
      blk_total[1] <= UHD_BLK_RST;
      dma_gate <= 2'h0;
    end else if (wr_en) begin
      if (paddr == UHD_EP1_CTL_OFS) begin
        pkt_size[0] <= pwdata[UHD_CTL_PKT_LSB +: PKT_W];
        auto_en[0] <= pwdata[UHD_CTL_AUTO_BIT];
      end else if (paddr == UHD_EP2_CTL_OFS) begin
        pkt_size[1] <= pwdata[UHD_CTL_PKT_LSB +: PKT_W];
        auto_en[1] <= pwdata[UHD_CTL_AUTO_BIT];
      end else if (paddr == UHD_EP1_BLK_OFS) begin
        blk_total[0] <= pwdata[CNT_W-1:0];
      end else if (paddr == UHD_EP2_BLK_OFS) begin
        blk_total[1] <= pwdata[CNT_W-1:0];
      end else if (paddr == UHD_DMA_GATE_OFS) begin
        dma_gate <= pwdata[1:0];
      end
    end
  end

  // Load one cycle after the write so the new total is used
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blk_load <= 2'h0;
    end else begin
      blk_load[0] <= wr_en && paddr == UHD_EP1_BLK_OFS;
      blk_load[1] <= wr_en && paddr == UHD_EP2_BLK_OFS;
    end
  end

  assign ep_clear = (wr_en && paddr == UHD_EP_EVENT_OFS) ?
                    pwdata[1:0] : 2'h0;

  // Each endpoint has a request engine of its own
  for (genvar i = 0; i < 2; i++) begin : g_ep
    uhd_ep_dma #(
      .PKT_W(PKT_W),
      .CNT_W(CNT_W)
    ) u_ep (
      .sys_clk(sys_clk),
      .rst(rst),
      .pkt_done(pkt_done[i]),
      .flag_clear(ep_clear[i]),
      .auto_en(auto_en[i]),
      .gate(dma_gate[i]),
      .max_pkt(pkt_size[i]),
      .load_total(blk_load[i]),
      .total(blk_total[i]),
      .dma_ack(dma_ack[i]),
      .flag(ep_flag[i]),
      .dma_req(ep_req[i]),
      .remaining(ep_left[i])
    );
  end

  assign dma_req = ep_req;

  uhd_detach_timer #(
    .CYCLES(DETACH_CYCLES),
    .CNT_W($clog2(DETACH_CYCLES + 1))
  ) u_detach (
    .sys_clk(sys_clk),
    .rst(rst),
    .se0(se0),
    .detach(detach_pulse)
  );

  // Attach state: bus reset clears it as a detach does, but sets no detach flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      attach_state <= 1'b0;
    end else if (detach_pulse || usb_bus_reset) begin
      attach_state <= 1'b0;
    end else if (connect_event) begin
      attach_state <= 1'b1;
    end
  end

  // Detach flag: hardware set wins over the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      detach_flag <= 1'b0;
    end else if (detach_pulse) begin
      detach_flag <= 1'b1;
    end else if (wr_en && paddr == UHD_HOST_EVENT_OFS &&
                 pwdata[UHD_EV_DETACH_BIT]) begin
      detach_flag <= 1'b0;
    end
  end

  assign resume_cause = !low_power_hold_bit || kstate ||
                        detach_pulse || connect_event;

  // Power state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_state <= UHD_PWR_ACTIVE;
    end else begin
      case (pwr_state)
        UHD_PWR_ACTIVE: begin
          if (low_power_hold_bit) begin
            pwr_state <= UHD_PWR_SUSPEND;
          end
        end
        UHD_PWR_SUSPEND: begin
          if (resume_cause) begin
            pwr_state <= UHD_PWR_RESUME;
          end
        end
        UHD_PWR_RESUME: begin
          pwr_state <= UHD_PWR_ACTIVE;
        end
        default: begin
          pwr_state <= UHD_PWR_ACTIVE;
        end
      endcase
    end
  end

  // Hold bit drops on its own when a line event wakes the bus
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_power_hold_bit <= 1'b0;
    end else if (pwr_state == UHD_PWR_SUSPEND && resume_cause) begin
      low_power_hold_bit <= 1'b0;
    end else if (wr_en && paddr == UHD_HOST_STATE_OFS) begin
      low_power_hold_bit <= pwdata[UHD_ST_HOLD_BIT];
    end
  end

  // Wake flag tells software tokens may go out again
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_event_flag <= 1'b0;
    end else if (pwr_state == UHD_PWR_RESUME) begin
      wake_event_flag <= 1'b1;
    end else if (wr_en && paddr == UHD_HOST_EVENT_OFS &&
                 pwdata[UHD_EV_WAKE_BIT]) begin
      wake_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      detach_irq_enable <= UHD_MASK_RST[UHD_EV_DETACH_BIT];
      wake_irq_enable <= UHD_MASK_RST[UHD_EV_WAKE_BIT];
    end else if (wr_en && paddr == UHD_HOST_MASK_OFS) begin
      detach_irq_enable <= pwdata[UHD_EV_DETACH_BIT];
      wake_irq_enable <= pwdata[UHD_EV_WAKE_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= (detach_flag && detach_irq_enable) ||
                  (wake_event_flag && wake_irq_enable);
    end
  end

  // Lines float in suspend; drive values follow the engine
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_oe <= 1'b0;
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      core_clk_run <= 1'b1;
    end else begin
      line_oe <= tx_oe && pwr_state == UHD_PWR_ACTIVE &&
                 !low_power_hold_bit;
      dp_out <= tx_dp;
      dm_out <= tx_dm;
      core_clk_run <= pwr_state != UHD_PWR_SUSPEND;
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == UHD_EP1_CTL_OFS) begin
      next_rdata[UHD_CTL_PKT_LSB +: PKT_W] = pkt_size[0];
      next_rdata[UHD_CTL_AUTO_BIT] = auto_en[0];
    end else if (paddr == UHD_EP2_CTL_OFS) begin
      next_rdata[UHD_CTL_PKT_LSB +: PKT_W] = pkt_size[1];
      next_rdata[UHD_CTL_AUTO_BIT] = auto_en[1];
    end else if (paddr == UHD_EP1_BLK_OFS) begin
      next_rdata[CNT_W-1:0] = blk_total[0];
    end else if (paddr == UHD_EP2_BLK_OFS) begin
      next_rdata[CNT_W-1:0] = blk_total[1];
    end else if (paddr == UHD_DMA_GATE_OFS) begin
      next_rdata[1:0] = dma_gate;
    end else if (paddr == UHD_EP_EVENT_OFS) begin
      next_rdata[1:0] = ep_flag;
    end else if (paddr == UHD_HOST_STATE_OFS) begin
      next_rdata[UHD_ST_ATTACH_BIT] = attach_state;
      next_rdata[UHD_ST_HOLD_BIT] = low_power_hold_bit;
    end else if (paddr == UHD_HOST_EVENT_OFS) begin
      next_rdata[UHD_EV_DETACH_BIT] = detach_flag;
      next_rdata[UHD_EV_WAKE_BIT] = wake_event_flag;
    end else if (paddr == UHD_HOST_MASK_OFS) begin
      next_rdata[UHD_EV_DETACH_BIT] = detach_irq_enable;
      next_rdata[UHD_EV_WAKE_BIT] = wake_irq_enable;
    end else if (paddr == UHD_EP_SIZE_OFS) begin
      // Size read first in per-packet receive
      next_rdata[PKT_W-1:0] = ep1_rx_size;
      next_rdata[UHD_SIZE2_LSB +: PKT_W] = ep2_rx_size;
    end else if (paddr == UHD_EP_LEFT_OFS) begin
      next_rdata[CNT_W-1:0] = ep_left[0];
      next_rdata[UHD_SIZE2_LSB +: CNT_W] = ep_left[1];
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= rd_en ? next_rdata : 32'h0000_0000;
      pslverr <= psel && penable && !pready && next_err;
    end
  end
endmodule : uhd_host_link
`default_nettype wire

/* inc/uhd_pkg.sv */
package uhd_pkg;
  // Register byte offsets on the APB window
  localparam logic [7:0] UHD_EP1_CTL_OFS = 8'h00;
  localparam logic [7:0] UHD_EP2_CTL_OFS = 8'h04;
  localparam logic [7:0] UHD_EP1_BLK_OFS = 8'h08;
  localparam logic [7:0] UHD_EP2_BLK_OFS = 8'h0C;
  localparam logic [7:0] UHD_DMA_GATE_OFS = 8'h10;
  localparam logic [7:0] UHD_EP_EVENT_OFS = 8'h14;
  localparam logic [7:0] UHD_HOST_STATE_OFS = 8'h18;
  localparam logic [7:0] UHD_HOST_EVENT_OFS = 8'h1C;
  localparam logic [7:0] UHD_HOST_MASK_OFS = 8'h20;
  localparam logic [7:0] UHD_EP_SIZE_OFS = 8'h24;
  localparam logic [7:0] UHD_EP_LEFT_OFS = 8'h28;
  // Field positions
  localparam int UHD_CTL_PKT_LSB = 0;
  localparam int UHD_CTL_AUTO_BIT = 16;
  localparam int UHD_ST_ATTACH_BIT = 0;
  localparam int UHD_ST_HOLD_BIT = 1;
  localparam int UHD_EV_DETACH_BIT = 0;
  localparam int UHD_EV_WAKE_BIT = 1;
  localparam int UHD_SIZE2_LSB = 16;
  // Reset values
  localparam logic [9:0] UHD_PKT_RST = 10'h040;
  localparam logic [15:0] UHD_BLK_RST = 16'h0000;
  localparam logic [1:0] UHD_MASK_RST = 2'h0;
  // Each DMA handshake moves one 16-bit word
  localparam int UHD_BYTES_PER_ACK = 2;
  // Detach interval: least time, rounded up to whole cycles
  localparam int UHD_CLK_PERIOD_NS = 5;
  localparam int UHD_DETACH_TIME_NS = 2500;
  localparam int UHD_DETACH_CYCLES =
    (UHD_DETACH_TIME_NS + UHD_CLK_PERIOD_NS - 1) / UHD_CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    UHD_PWR_ACTIVE = 2'b00,
    UHD_PWR_SUSPEND = 2'b01,
    UHD_PWR_RESUME = 2'b10
  } uhd_pwr_type;
endpackage : uhd_pkg

/* sim/uhd_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uhd_dma_model (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] gap, // Idle cycles after an ack, beyond the first
  input wire logic [1:0] dma_req, // Requests seen
  output logic [1:0] dma_ack // One word moved
);
  logic [3:0] wait_cnt [2];
  // Pause after each ack so a withdrawn request is seen first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dma_ack <= 2'h0;
      wait_cnt <= '{default: 4'h0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (dma_ack[i]) begin
          dma_ack[i] <= 1'b0;
          wait_cnt[i] <= gap;
        end else if (wait_cnt[i] != 4'h0) begin
          wait_cnt[i] <= wait_cnt[i] - 4'h1;
        end else begin
          dma_ack[i] <= dma_req[i];
        end
      end
    end
  end
endmodule : uhd_dma_model
`default_nettype wire

/* sim/uhd_host_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module uhd_host_link_properties #(
  parameter int PKT_W = 10,
  parameter int DETACH_CYCLES = uhd_pkg::UHD_DETACH_CYCLES
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [1:0] pkt_done, // Packet end
  input wire logic [1:0] dma_ack, // DMA ack
  input wire logic [1:0] dma_req, // DMA request
  input wire logic dp_in, // D+ level
  input wire logic dm_in, // D- level
  input wire logic line_oe, // Line enable
  input wire logic core_clk_run, // Clock request
  input wire logic host_irq // Interrupt
);
  import uhd_pkg::*;
  logic wr;
  logic auto_q;
  logic [1:0] gate_q, mask_q;
  logic [PKT_W-1:0] pkt_q;
  logic [15:0] bytes, se0_cnt;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  // Shadow copies of the fields the properties depend on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_q <= 2'h0;
      mask_q <= 2'h0;
      auto_q <= 1'b0;
      pkt_q <= UHD_PKT_RST;
    end else if (wr) begin
      if (paddr == UHD_DMA_GATE_OFS) gate_q <= pwdata[1:0];
      if (paddr == UHD_HOST_MASK_OFS) mask_q <= pwdata[1:0];
      if (paddr == UHD_EP1_CTL_OFS) begin
        auto_q <= pwdata[UHD_CTL_AUTO_BIT];
        pkt_q <= pwdata[PKT_W-1:0];
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bytes <= 16'h0000;
      se0_cnt <= 16'h0000;
    end else begin
      if (!dma_req[0]) bytes <= 16'h0000;
      else if (dma_ack[0]) bytes <= bytes + 16'h0002;
      if (dp_in || dm_in) se0_cnt <= 16'h0000;
      else if (se0_cnt != 16'hFFFF) se0_cnt <= se0_cnt + 16'h0001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence k_state;
    (!core_clk_run && !dp_in && dm_in) [*3];
  endsequence
  sequence hold_wr;
    wr && paddr == UHD_HOST_STATE_OFS && pwdata[UHD_ST_HOLD_BIT];
  endsequence
  req_gate_a: assert property (dma_req[0] |->
    gate_q[0] || $past(gate_q[0])) else $error("request without gate");
  pkt_req_a: assert property (pkt_done[0] && gate_q[0] && !auto_q
    |=> dma_req[0]) else $error("packet end raised no request");
  auto_drop_a: assert property (auto_q && dma_req[0] && dma_ack[0] &&
    bytes + 16'h0002 >= 16'(pkt_q) |=> !dma_req[0])
    else $error("auto request kept after full packet");
  packet_hold_a: assert property (!auto_q && gate_q[0] && dma_ack[0] &&
    dma_req[0] && !(wr && paddr == UHD_EP_EVENT_OFS) |=> dma_req[0])
    else $error("packet mode request dropped by ack");
  detach_early_a: assert property ($rose(host_irq) && mask_q == 2'h1
    |-> se0_cnt >= DETACH_CYCLES) else $error("detach too early");
  detach_late_a: assert property (se0_cnt == DETACH_CYCLES && mask_q[0]
    |-> ##[1:8] host_irq) else $error("detach not flagged");
  suspend_float_a: assert property (hold_wr |->
    ##3 (!line_oe && !core_clk_run)) else $error("suspend not entered");
  kstate_wake_a: assert property (k_state ##0 mask_q[1] |->
    ##[1:10] (core_clk_run && host_irq)) else $error("no wake on K state");
endmodule : uhd_host_link_properties
`default_nettype wire

/* sim/uhd_host_link_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin err_count++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (g), (x)); end end
module uhd_host_link_tb;
  import uhd_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, usb_bus_reset, rerr;
  logic tx_dp, tx_dm, tx_oe, dev_dp, dev_dm;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdat;
  logic [1:0] pkt_done;
  logic [9:0] ep1_rx_size, ep2_rx_size;
  logic [3:0] gap;
  wire [31:0] prdata;
  wire [1:0] dma_ack, dma_req;
  wire pready, pslverr, dp_in, dm_in, dp_out, dm_out, line_oe;
  wire core_clk_run, host_irq;
  int err_count, comparisons, ackc;
  // Shared wire: the host wins while it drives
  assign dp_in = line_oe ? dp_out : dev_dp;
  assign dm_in = line_oe ? dm_out : dev_dm;
  uhd_host_link #(.DETACH_CYCLES(8)) i_uhd_host_link (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pkt_done(pkt_done),
    .ep1_rx_size(ep1_rx_size), .ep2_rx_size(ep2_rx_size),
    .usb_bus_reset(usb_bus_reset), .dma_ack(dma_ack), .dma_req(dma_req),
    .dp_in(dp_in), .dm_in(dm_in), .tx_dp(tx_dp), .tx_dm(tx_dm),
    .tx_oe(tx_oe), .dp_out(dp_out), .dm_out(dm_out), .line_oe(line_oe),
    .core_clk_run(core_clk_run), .host_irq(host_irq));
  uhd_dma_model i_uhd_dma_model (.sys_clk(sys_clk), .rst(rst), .gap(gap),
    .dma_req(dma_req), .dma_ack(dma_ack));
  always @(posedge sys_clk) if (dma_ack[0] === 1'b1) ackc++;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, x)
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic pulse(input logic [1:0] m);
    @(posedge sys_clk);
    pkt_done <= m;
    @(posedge sys_clk);
    pkt_done <= 2'h0;
  endtask : pulse
  task automatic lines(input logic p, input logic m);
    @(posedge sys_clk);
    dev_dp <= p;
    dev_dm <= m;
  endtask : lines
  task automatic wait_low();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (dma_req[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      err_count++;
      print_verdict();
    end
  endtask : wait_low
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, tx_dp, dev_dp} = 3'h7;
    {psel, penable, pwrite, usb_bus_reset, tx_dm, tx_oe, dev_dm} = 7'h00;
    {paddr, pwdata, pkt_done, gap} = '0;
    ep1_rx_size = 10'h123;
    ep2_rx_size = 10'h02A;
    {err_count, comparisons, ackc} = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    settle(0);
    `CHK({dma_req, host_irq, core_clk_run}, 4'h1)
    rd(UHD_EP1_CTL_OFS, 32'h0000_0040);
    rd(UHD_EP1_BLK_OFS, 32'h0);
    rd(UHD_HOST_STATE_OFS, 32'h1);
    apb(1'b0, 8'h3C, 32'h0);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    rd(UHD_EP_SIZE_OFS, 32'h002A_0123);
    pulse(2'h1);
    settle(1);
    `CHK(dma_req, 2'h0)
    rd(UHD_EP_EVENT_OFS, 32'h1);
    wr(UHD_DMA_GATE_OFS, 32'h3);
    pulse(2'h3);
    settle(6);
    `CHK({dma_req, ackc > 0}, 3'h7)
    wr(UHD_EP_EVENT_OFS, 32'h3);
    settle(2);
    `CHK(dma_req, 2'h0)
    @(posedge sys_clk) gap <= 4'h3;
    wr(UHD_EP1_BLK_OFS, 32'hC);
    wr(UHD_EP1_CTL_OFS, 32'h0001_0008);
    rd(UHD_EP_LEFT_OFS, 32'hC);
    ackc = 0;
    pulse(2'h1);
    wait_low();
    `CHK(ackc, 4)
    rd(UHD_EP_LEFT_OFS, 32'h4);
    pulse(2'h1);
    wait_low();
    `CHK(ackc, 6)
    pulse(2'h1);
    settle(6);
    `CHK({dma_req[0], ackc == 6}, 2'h1)
    wr(UHD_EP1_CTL_OFS, 32'h8);
    settle(6);
    `CHK(dma_req[0], 1'b1)
    wr(UHD_EP_EVENT_OFS, 32'h1);
    wr(UHD_HOST_MASK_OFS, 32'h1);
    lines(1'b0, 1'b0);
    settle(5);
    lines(1'b1, 1'b0);
    rd(UHD_HOST_EVENT_OFS, 32'h0);
    lines(1'b0, 1'b0);
    settle(14);
    `CHK(host_irq, 1'b1)
    rd(UHD_HOST_STATE_OFS, 32'h0);
    rd(UHD_HOST_EVENT_OFS, 32'h1);
    lines(1'b1, 1'b0);
    wr(UHD_HOST_EVENT_OFS, 32'h1);
    settle(1);
    `CHK(host_irq, 1'b0)
    wr(UHD_HOST_MASK_OFS, 32'h0);
    lines(1'b0, 1'b0);
    settle(14);
    `CHK(host_irq, 1'b0)
    rd(UHD_HOST_EVENT_OFS, 32'h1);
    lines(1'b1, 1'b0);
    wr(UHD_HOST_EVENT_OFS, 32'h1);
    wr(UHD_HOST_MASK_OFS, 32'h1);
    settle(4);
    // Reset held over the read so the idle lines cannot re-attach first
    lines(1'b0, 1'b0);
    usb_bus_reset <= 1'b1;
    rd(UHD_HOST_STATE_OFS, 32'h0);
    lines(1'b1, 1'b0);
    usb_bus_reset <= 1'b0;
    rd(UHD_HOST_EVENT_OFS, 32'h0);
    @(posedge sys_clk) tx_oe <= 1'b1;
    settle(2);
    `CHK({line_oe, dp_out, dm_out, host_irq}, 4'hC)
    wr(UHD_HOST_MASK_OFS, 32'h2);
    wr(UHD_HOST_STATE_OFS, 32'h2);
    settle(2);
    `CHK({line_oe, core_clk_run}, 2'h0)
    wr(UHD_HOST_STATE_OFS, 32'h0);
    settle(4);
    `CHK({line_oe, core_clk_run, host_irq}, 3'h7)
    rd(UHD_HOST_EVENT_OFS, 32'h2);
    wr(UHD_HOST_EVENT_OFS, 32'h2);
    wr(UHD_HOST_STATE_OFS, 32'h2);
    settle(2);
    `CHK(core_clk_run, 1'b0)
    lines(1'b0, 1'b1);
    settle(8);
    `CHK({core_clk_run, host_irq}, 2'h3)
    rd(UHD_HOST_STATE_OFS, 32'h1);
    lines(1'b1, 1'b0);
    wr(UHD_HOST_EVENT_OFS, 32'h2);
    settle(1);
    `CHK(host_irq, 1'b0)
    // Even block of four: DMA moves all four bytes in two words
    wr(UHD_EP1_CTL_OFS, 32'h0001_0008);
    wr(UHD_EP1_BLK_OFS, 32'h4);
    ackc = 0;
    pulse(2'h1);
    wait_low();
    `CHK(ackc, 2)
    // Odd block by DMA: one surplus byte rides in the last word
    wr(UHD_EP1_BLK_OFS, 32'h5);
    ackc = 0;
    pulse(2'h1);
    wait_low();
    `CHK(ackc, 3)
    rd(UHD_EP_LEFT_OFS, 32'h0);
    print_verdict();
  end
endmodule : uhd_host_link_tb
bind uhd_host_link uhd_host_link_properties #(.PKT_W(PKT_W),
  .DETACH_CYCLES(DETACH_CYCLES)) i_uhd_host_link_properties (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .pkt_done(pkt_done), .dma_ack(dma_ack),
  .dma_req(dma_req), .dp_in(dp_in), .dm_in(dm_in), .line_oe(line_oe),
  .core_clk_run(core_clk_run), .host_irq(host_irq));
`default_nettype wire
